// ---- src/timer_event_irq_defines.svh ----
// register indices, field positions and reset values of the event/irq timer slice
// assumes: included by bare name from every file that needs a number
`ifndef TIMER_EVENT_IRQ_DEFINES_SVH
`define TIMER_EVENT_IRQ_DEFINES_SVH

// ==========================================
// register indices (byte address = 4 * index)
`define IDX_CONTROL_A      8'h00
`define IDX_CONTROL_E      8'h05
`define IDX_BUF_VALID      8'h06
`define IDX_EVENT_CONTROL  8'h09
`define IDX_INT_ENABLE     8'h0a
`define IDX_INT_FLAGS      8'h0b
`define IDX_COUNT          8'h20
`define IDX_PERIOD         8'h26
`define IDX_COMPARE0       8'h28
`define IDX_PERIOD_BUF     8'h36
`define IDX_COMPARE_BUF0   8'h38
`define IDX_STRIDE         8'h02

// ==========================================
// values and fields
`define PERIOD_RESET       16'hffff
`define REG8_RESET         8'h00
`define IRQ_VALID_MASK     8'h71
`define BIT_WRAP           0
`define BIT_COMPARE_CHANNEL0_IRQ           4
`define CMD_UPDATE         2'h1
`define ADDR_HI_ZERO       2'h0

`endif

// ---- src/timer_event_irq_pkg.sv ----
// types shared by the event/irq timer slice
// assumes: numbers live in timer_event_irq_defines.svh
package timer_event_irq_pkg;

  // ==========================================
  // enumerations
  typedef enum logic [2:0] {
    count_rising_edge    = 3'h0,
    count_both_edges     = 3'h1,
    count_while_high     = 3'h2,
    event_sets_direction = 3'h3
  } event_action_t;

  typedef enum logic [2:0] {
    wave_normal   = 3'h0,
    wave_freq     = 3'h1,
    wave_single   = 3'h3,
    wave_ds_top   = 3'h5,
    wave_ds_both  = 3'h6,
    wave_ds_bot   = 3'h7
  } waveform_t;

  // ==========================================
  // register layouts
  typedef struct packed {
    logic [3:0] unused;
    logic [2:0] event_action;
    logic       event_count_enable;
  } event_control_t;

  typedef struct packed {
    logic       unused;
    logic [2:0] waveform_select;
    logic [2:0] prescale_sel;
    logic       run;
  } control_a_t;

  typedef struct packed {
    logic [5:0] unused;
    logic       update_lock;
    logic       count_down;
  } control_e_t;

endpackage

// ---- src/timer_prescaler.sv ----
// prescaler: one-cycle tick every 2**sel pclk cycles while running
// assumes: pclk is the only clock; sel comes from a register on pclk
`timescale 1ns/100ps
module timer_prescaler #(
  parameter int PRESCALE_W = 7
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output logic            tick
);

  logic [PRESCALE_W-1:0] pre_q;
  logic [PRESCALE_W-1:0] mask;

  // ==========================================
  // divider
  assign mask = PRESCALE_W'((1 << sel) - 1);
  assign tick = run && ((pre_q & mask) == mask);

  // stopped divider restarts from zero so the first tick is a full period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else if (!run) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

endmodule

// ---- src/timer_event_irq_control.sv ----
// event counting, buffer-valid tracking and interrupt flags of a 16-bit timer
// assumes: APB3 master on pclk; event_in may come from any domain
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`include "timer_event_irq_defines.svh"

// Notes on behaviour
// - a compare buffer write sets that channel's buffer-valid bit
// - an update clears all compare buffer-valid bits by itself
// - a period buffer write sets period buffer-valid, bit 0
// - an update clears period buffer-valid by itself
// - event control at 0x09, reset 0x00, event action in bits 3:1
// - action 0 counts each rising event edge when enabled
// - action 1 counts every event edge when enabled
// - action 2 counts prescaled ticks while event is high
// - action 3 counts ticks, up while event low, down while high
// - enable bit 0 off means event input is ignored
// - interrupt enable 0x0a, compare enables at bits 4 to 6
// - interrupt enable bit 0 enables wrap interrupt
// - flags at 0x0b, reset 0x00, compares 4 to 6, wrap 0
// - compare flag sets when counter equals channel compare value
// - flags stay until software writes one; zero leaves them
// - wrap flag sets at top or bottom as waveform mode says
// - update copies buffers to working registers unless locked
module timer_event_irq_control
  import timer_event_irq_pkg::*;
#(
  parameter int PRESCALE_W = 7
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        event_in,
  output logic             irq
);

  // ==========================================
  // helpers
  function automatic logic [2:0] ch_hit(input logic [7:0] idx, input logic [7:0] base);
    logic [2:0] h;
    h = '0;
    for (int n = 0; n < 3; n++) begin
      h[n] = (idx == base + 8'(`IDX_STRIDE * n));
    end
    return h;
  endfunction

  // ==========================================
  // state
  control_a_t     ctrl_a_q;
  control_e_t     ctrl_e_q;
  event_control_t evc_q;
  logic [7:0]     ien_q;
  logic [7:0]     iflag_q;
  logic [7:0]     iflag_d;
  logic [3:0]     bv_q;
  logic [15:0]    cnt_q;
  logic [15:0]    per_q;
  logic [15:0]    period_buffer_q;
  logic [15:0]    cmp_q    [3];
  logic [15:0]    cmpbuf_q [3];
  logic [2:0]     match_q;
  logic           ev_s1_q;
  logic           ev_s2_q;
  logic           ev_s3_q;
  logic [31:0]    rd_d;
  logic           err_d;
  logic [31:0]    prdata_q;
  logic           pslverr_q;

  logic [7:0]  idx;
  logic        addr_ok;
  logic        wr;
  logic        setup;
  logic [15:0] wdata16;
  logic [2:0]  wr_cmp;
  logic [2:0]  wr_cmpbuf;
  logic        wr_period_buffer;
  logic        wr_cnt;
  logic        force_upd;
  logic        tick;
  logic        rise;
  logic        any_edge;
  logic        step;
  logic        eff_down;
  logic [15:0] top;
  logic        at_top;
  logic        at_bot;
  logic        hit_top;
  logic        hit_bot;
  logic        dual;
  logic        upd_cond;
  logic        upd_go;
  logic        wrap_set;
  logic [2:0]  match_now;
  logic [7:0]  flag_set;
  logic [7:0]  flag_clr;

  // ==========================================
  // apb decode
  assign idx       = paddr[9:2];
  assign addr_ok   = (paddr[11:10] == `ADDR_HI_ZERO);
  assign wr        = psel && penable && pwrite && addr_ok;
  assign setup     = psel && !penable;
  assign wdata16   = pwdata[15:0];
  assign wr_cmp    = wr ? ch_hit(idx, `IDX_COMPARE0) : 3'h0;
  assign wr_cmpbuf = wr ? ch_hit(idx, `IDX_COMPARE_BUF0) : 3'h0;
  assign wr_period_buffer = wr && (idx == `IDX_PERIOD_BUF);
  assign wr_cnt    = wr && (idx == `IDX_COUNT);
  assign force_upd = wr && (idx == `IDX_CONTROL_E) && (pwdata[3:2] == `CMD_UPDATE);
  assign pready    = 1'b1;
  assign prdata    = prdata_q;
  assign pslverr   = pslverr_q;

  // read data is sampled in the setup cycle so prdata leaves a flop
  always_comb begin
    rd_d  = '0;
    err_d = 1'b0;
    unique case (idx)
      `IDX_CONTROL_A:     rd_d[7:0] = ctrl_a_q;
      `IDX_CONTROL_E:     rd_d[7:0] = ctrl_e_q;
      `IDX_BUF_VALID:     rd_d[3:0] = bv_q;
      `IDX_EVENT_CONTROL: rd_d[7:0] = evc_q;
      `IDX_INT_ENABLE:    rd_d[7:0] = ien_q;
      `IDX_INT_FLAGS:     rd_d[7:0] = iflag_q;
      `IDX_COUNT:         rd_d[15:0] = cnt_q;
      `IDX_PERIOD:        rd_d[15:0] = per_q;
      `IDX_PERIOD_BUF:    rd_d[15:0] = period_buffer_q;
      default: begin
        err_d = 1'b1;
        for (int n = 0; n < 3; n++) begin
          if (ch_hit(idx, `IDX_COMPARE0) == 3'(1 << n)) begin
            rd_d[15:0] = cmp_q[n];
            err_d      = 1'b0;
          end
          if (ch_hit(idx, `IDX_COMPARE_BUF0) == 3'(1 << n)) begin
            rd_d[15:0] = cmpbuf_q[n];
            err_d      = 1'b0;
          end
        end
      end
    endcase
    if (!addr_ok) begin
      rd_d  = '0;
      err_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_d;
      pslverr_q <= err_d;
    end
  end

  // ==========================================
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_q <= `REG8_RESET;
      evc_q    <= `REG8_RESET;
      ien_q    <= `REG8_RESET;
    end else if (wr) begin
      if (idx == `IDX_CONTROL_A) ctrl_a_q <= {1'b0, pwdata[6:0]};
      if (idx == `IDX_EVENT_CONTROL) evc_q <= {4'h0, pwdata[3:0]};
      if (idx == `IDX_INT_ENABLE) ien_q <= pwdata[7:0] & `IRQ_VALID_MASK;
    end
  end

  // ==========================================
  // event input: two flops before use, third only for edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_s1_q <= 1'b0;
      ev_s2_q <= 1'b0;
      ev_s3_q <= 1'b0;
    end else begin
      ev_s1_q <= event_in;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
    end
  end

  assign rise     = ev_s2_q && !ev_s3_q;
  assign any_edge = ev_s2_q ^ ev_s3_q;

  timer_prescaler #(
    .PRESCALE_W (PRESCALE_W)
  ) u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (ctrl_a_q.run),
    .sel     (ctrl_a_q.prescale_sel),
    .tick    (tick)
  );

  // ==========================================
  // count step selection
  always_comb begin
    step     = 1'b0;
    eff_down = ctrl_e_q.count_down;
    if (ctrl_a_q.run) begin
      if (evc_q.event_count_enable) begin
        unique case (evc_q.event_action)
          count_rising_edge:    step = rise;
          count_both_edges:     step = any_edge;
          count_while_high:     step = tick && ev_s2_q;
          event_sets_direction: begin
            step     = tick;
            eff_down = ev_s2_q;
          end
          default:              step = tick;
        endcase
      end else begin
        step = tick;
      end
    end
  end

  // ==========================================
  // counter core, top and bottom detection
  assign top      = (ctrl_a_q.waveform_select == wave_freq) ? cmp_q[0] : per_q;
  assign at_top   = (cnt_q == top);
  assign at_bot   = (cnt_q == 16'h0000);
  assign hit_top  = step && !eff_down && at_top;
  assign hit_bot  = step && eff_down && at_bot;
  assign dual     = ctrl_a_q.waveform_select[2] && ctrl_a_q.waveform_select[0] ||
                    (ctrl_a_q.waveform_select == wave_ds_both);

  // bus write to the counter wins over a count step in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q    <= '0;
      ctrl_e_q <= `REG8_RESET;
    end else begin
      if (wr_cnt) begin
        cnt_q <= wdata16;
      end else if (hit_top) begin
        cnt_q <= dual ? cnt_q - 1'b1 : 16'h0000;
      end else if (hit_bot) begin
        cnt_q <= dual ? cnt_q + 1'b1 : top;
      end else if (step) begin
        cnt_q <= eff_down ? cnt_q - 1'b1 : cnt_q + 1'b1;
      end
      if (wr && idx == `IDX_CONTROL_E) begin
        ctrl_e_q <= {6'h00, pwdata[1:0]};
      end else if (dual && hit_top) begin
        ctrl_e_q.count_down <= 1'b1;
      end else if (dual && hit_bot) begin
        ctrl_e_q.count_down <= 1'b0;
      end
    end
  end

  // ==========================================
  // update condition and buffered registers
  always_comb begin
    unique case (ctrl_a_q.waveform_select)
      wave_normal, wave_freq: begin
        upd_cond = hit_top || hit_bot;
        wrap_set = hit_top || hit_bot;
      end
      wave_ds_top: begin
        upd_cond = hit_bot;
        wrap_set = hit_top;
      end
      wave_ds_both: begin
        upd_cond = hit_bot;
        wrap_set = hit_top || hit_bot;
      end
      default: begin
        upd_cond = hit_bot;
        wrap_set = hit_bot;
      end
    endcase
  end

  assign upd_go = (upd_cond || force_upd) && !ctrl_e_q.update_lock;

  // a write in the update cycle wins so the new value is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bv_q <= 4'h0;
    end else begin
      for (int n = 0; n < 3; n++) begin
        if (wr_cmpbuf[n]) bv_q[n+1] <= 1'b1;
        else if (upd_go) bv_q[n+1] <= 1'b0;
      end
      if (wr_period_buffer) bv_q[0] <= 1'b1;
      else if (upd_go) bv_q[0] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_q    <= `PERIOD_RESET;
      period_buffer_q <= `PERIOD_RESET;
      cmp_q    <= '{default: '0};
      cmpbuf_q <= '{default: '0};
    end else begin
      if (wr_period_buffer) period_buffer_q <= wdata16;
      if (wr && idx == `IDX_PERIOD) per_q <= wdata16;
      else if (upd_go) per_q <= period_buffer_q;
      for (int n = 0; n < 3; n++) begin
        if (wr_cmpbuf[n]) cmpbuf_q[n] <= wdata16;
        if (wr_cmp[n]) cmp_q[n] <= wdata16;
        else if (upd_go) cmp_q[n] <= cmpbuf_q[n];
      end
    end
  end

  // ==========================================
  // interrupt flags, arrival edge of a match so a held match sets once
  always_comb begin
    for (int n = 0; n < 3; n++) begin
      match_now[n] = (cnt_q == cmp_q[n]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // counter and compares reset equal: a standing match must not flag after reset
      match_q <= '1;
    end else begin
      match_q <= match_now;
    end
  end

  assign flag_set = {1'b0, match_now & ~match_q, 3'h0, wrap_set};
  assign flag_clr = (wr && idx == `IDX_INT_FLAGS) ? (pwdata[7:0] & `IRQ_VALID_MASK) : 8'h00;
  assign iflag_d  = (iflag_q & ~flag_clr) | flag_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iflag_q <= `REG8_RESET;
    end else begin
      iflag_q <= iflag_d;
    end
  end

  assign irq = |(iflag_q & ien_q);

  // ==========================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_cmpbuf_valid;
    wr_cmpbuf[1] |=> bv_q[2];
  endproperty
  a_cmpbuf_valid: assert property (p_cmpbuf_valid) else $error("compare1 valid not set");

  property p_upd_clears;
    upd_go && (wr_cmpbuf == 3'h0) && !wr_period_buffer |=> (bv_q == 4'h0);
  endproperty
  a_upd_clears: assert property (p_upd_clears) else $error("buffer valid not cleared");

  property p_period_buffer_valid;
    wr_period_buffer |=> bv_q[0];
  endproperty
  a_period_buffer_valid: assert property (p_period_buffer_valid) else $error("period valid not set");

  property p_rise_counts;
    ctrl_a_q.run && evc_q.event_count_enable && evc_q.event_action == count_rising_edge
      && $rose(ev_s2_q) && !wr_cnt && !at_top && !eff_down |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_rise_counts: assert property (p_rise_counts) else $error("rising event not counted");

  property p_high_only;
    evc_q.event_count_enable && evc_q.event_action == count_while_high && step |-> ev_s2_q;
  endproperty
  a_high_only: assert property (p_high_only) else $error("counted while event low");

  property p_updown_dir;
    ctrl_a_q.run && evc_q.event_count_enable && evc_q.event_action == event_sets_direction
      && tick && ev_s2_q && !at_bot && !wr_cnt |=> cnt_q == $past(cnt_q) - 16'h0001;
  endproperty
  a_updown_dir: assert property (p_updown_dir) else $error("event high did not count down");

  property p_disabled_ticks;
    !evc_q.event_count_enable |-> step == tick;
  endproperty
  a_disabled_ticks: assert property (p_disabled_ticks) else $error("event steered disabled counter");

  property p_flag_sticky;
    iflag_q[`BIT_COMPARE_CHANNEL0_IRQ] && !flag_clr[`BIT_COMPARE_CHANNEL0_IRQ] |=> iflag_q[`BIT_COMPARE_CHANNEL0_IRQ];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by itself");

  property p_match_flag;
    match_now[2] && !match_q[2] |=> iflag_q[`BIT_COMPARE_CHANNEL0_IRQ + 2];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("compare2 flag missed");

  property p_irq_gate;
    irq |-> (iflag_q[`BIT_WRAP] && ien_q[`BIT_WRAP]) || |(iflag_q[6:4] & ien_q[6:4]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enabled flag");

  property p_lock_holds;
    (upd_cond || force_upd) && ctrl_e_q.update_lock && !wr_cmp[0] |=> $stable(cmp_q[0]);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("locked update copied");

endmodule

// ---- dv/event_source.sv ----
// partner model: the event routing network driving the timer's count event
// assumes: one pclk domain; the level is changed just after a rising edge
`timescale 1ns/100ps
module event_source (
  input  wire logic pclk,
  output logic      event_in
);
  initial event_in = 1'b0;

  // ==========================================
  // drive tasks
  // levels last whole cycles: shorter pulses may be lost in the sync flops
  task automatic hold(input logic v, input int cycles);
    @(posedge pclk);
    event_in <= v;
    repeat (cycles - 1) @(posedge pclk);
  endtask

  task automatic pulses(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      hold(1'b1, hi);
      hold(1'b0, lo);
    end
  endtask
endmodule

// ---- dv/testbench.sv ----
// self-checking bench of the event/irq timer slice over apb
// assumes: design files in src/, event_source partner model in dv/
`timescale 1ns/100ps
`include "timer_event_irq_defines.svh"
module testbench;
  import timer_event_irq_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        event_in;
  logic        irq;
  logic [31:0] r1;
  logic [31:0] r2;
  logic        er;
  int          err_count;
  int          tests_run;
  int          cycles;

  timer_event_irq_control dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_in(event_in), .irq(irq)
  );
  event_source partner (.pclk(pclk), .event_in(event_in));

  // ==========================================
  // clock, reset, timeout
  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;
  // whole run is well under a thousand cycles; the ceiling leaves wide margin
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end

  // ==========================================
  // bus and compare tasks
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rdv, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {`ADDR_HI_ZERO, idx, 2'h0};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here: only the bench timeout ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, r1, er);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string msg);
    apb(1'b0, idx, 32'h0, r2, er);
    chk(r2, exp, msg);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset;
    rdchk(`IDX_EVENT_CONTROL, 32'h0, "event control reset");
    rdchk(`IDX_INT_ENABLE, 32'h0, "irq enable reset");
    rdchk(`IDX_INT_FLAGS, 32'h0, "irq flags reset");
    rdchk(`IDX_BUF_VALID, 32'h0, "buffer valid reset");
    apb(1'b0, 8'h0e, 32'h0, r2, er);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(r2, 32'h0, "unmapped data");
    $display("test reset done");
  endtask

  task automatic t_regs;
    wr(`IDX_EVENT_CONTROL, 32'h0f);
    rdchk(`IDX_EVENT_CONTROL, 32'h0f, "event control rw");
    wr(`IDX_INT_ENABLE, 32'hff);
    rdchk(`IDX_INT_ENABLE, 32'h71, "irq enable bits");
    wr(`IDX_INT_ENABLE, 32'h0);
    wr(`IDX_EVENT_CONTROL, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_bufvalid;
    wr(`IDX_PERIOD_BUF, 32'h40);
    rdchk(`IDX_BUF_VALID, 32'h01, "period valid");
    wr(`IDX_COMPARE_BUF0, 32'h11);
    rdchk(`IDX_BUF_VALID, 32'h03, "compare0 valid");
    wr(`IDX_COMPARE_BUF0 + `IDX_STRIDE, 32'h22);
    wr(`IDX_COMPARE_BUF0 + 2 * `IDX_STRIDE, 32'h33);
    rdchk(`IDX_BUF_VALID, 32'h0f, "all valid");
    wr(`IDX_CONTROL_E, 32'h02);
    wr(`IDX_CONTROL_E, 32'h06);
    rdchk(`IDX_BUF_VALID, 32'h0f, "locked update keeps valid");
    rdchk(`IDX_COMPARE0, 32'h0, "locked update no copy");
    // lock acts as it stood before the write, so release it before the command
    wr(`IDX_CONTROL_E, 32'h00);
    wr(`IDX_CONTROL_E, 32'h04);
    rdchk(`IDX_BUF_VALID, 32'h0, "update clears valid");
    rdchk(`IDX_COMPARE0, 32'h11, "compare0 copied");
    rdchk(`IDX_COMPARE0 + 2 * `IDX_STRIDE, 32'h33, "compare2 copied");
    rdchk(`IDX_PERIOD, 32'h40, "period copied");
    $display("test bufvalid done");
  endtask

  // slow prescale keeps stray ticks to at most one in the window
  task automatic ev_run(input logic [2:0] act, input logic en, input logic [2:0] sel,
                        input int n, input int hi, input int lo_exp, input int hi_exp, input string msg);
    wr(`IDX_CONTROL_A, {28'h0, sel, 1'b1});
    wr(`IDX_EVENT_CONTROL, {28'h0, act, en});
    wr(`IDX_COUNT, 32'h0);
    partner.pulses(n, hi, 3);
    repeat (6) @(posedge pclk);
    apb(1'b0, `IDX_COUNT, 32'h0, r2, er);
    chk({31'h0, (r2 >= lo_exp && r2 <= hi_exp)}, 32'h1, msg);
    wr(`IDX_CONTROL_A, 32'h0);
    wr(`IDX_EVENT_CONTROL, 32'h0);
  endtask

  task automatic t_events;
    ev_run(count_rising_edge, 1'b1, 3'h7, 5, 3, 5, 5, "rising edges");
    ev_run(count_both_edges, 1'b1, 3'h7, 5, 3, 10, 10, "both edges");
    ev_run(count_while_high, 1'b1, 3'h0, 1, 20, 20, 20, "high level");
    ev_run(count_rising_edge, 1'b0, 3'h7, 5, 3, 0, 1, "disabled");
    ev_run(3'h4, 1'b1, 3'h7, 5, 3, 0, 1, "reserved action");
    $display("test events done");
  endtask

  task automatic t_updown;
    logic [31:0] a;
    wr(`IDX_EVENT_CONTROL, {28'h0, event_sets_direction, 1'b1});
    wr(`IDX_COUNT, 32'h20);
    wr(`IDX_CONTROL_A, 32'h01);
    apb(1'b0, `IDX_COUNT, 32'h0, a, er);
    apb(1'b0, `IDX_COUNT, 32'h0, r2, er);
    chk({31'h0, r2 > a}, 32'h1, "up while low");
    partner.hold(1'b1, 4);
    apb(1'b0, `IDX_COUNT, 32'h0, a, er);
    apb(1'b0, `IDX_COUNT, 32'h0, r2, er);
    chk({31'h0, r2 < a}, 32'h1, "down while high");
    partner.hold(1'b0, 1);
    wr(`IDX_CONTROL_A, 32'h0);
    wr(`IDX_EVENT_CONTROL, 32'h0);
    $display("test updown done");
  endtask

  task automatic t_irq;
    wr(`IDX_INT_FLAGS, 32'h71);
    wr(`IDX_PERIOD, 32'h40);
    wr(`IDX_COMPARE0, 32'h10);
    wr(`IDX_COMPARE0 + `IDX_STRIDE, 32'h20);
    wr(`IDX_COMPARE0 + 2 * `IDX_STRIDE, 32'h30);
    wr(`IDX_COUNT, 32'h0);
    wr(`IDX_CONTROL_A, 32'h01);
    repeat (100) @(posedge pclk);
    wr(`IDX_CONTROL_A, 32'h0);
    rdchk(`IDX_INT_FLAGS, 32'h71, "match and wrap flags");
    #1 chk({31'h0, irq}, 32'h0, "masked irq");
    wr(`IDX_INT_ENABLE, 32'h10);
    #1 chk({31'h0, irq}, 32'h1, "compare0 irq");
    wr(`IDX_INT_FLAGS, 32'h0);
    rdchk(`IDX_INT_FLAGS, 32'h71, "zero write keeps flags");
    wr(`IDX_INT_FLAGS, 32'h10);
    rdchk(`IDX_INT_FLAGS, 32'h61, "one clears flag");
    #1 chk({31'h0, irq}, 32'h0, "irq drops");
    wr(`IDX_INT_ENABLE, 32'h01);
    #1 chk({31'h0, irq}, 32'h1, "wrap irq");
    wr(`IDX_INT_FLAGS, 32'h71);
    rdchk(`IDX_INT_FLAGS, 32'h0, "all cleared");
    #1 chk({31'h0, irq}, 32'h0, "irq clear");
    wr(`IDX_CONTROL_E, 32'h01);
    wr(`IDX_COUNT, 32'h08);
    wr(`IDX_CONTROL_A, 32'h01);
    repeat (20) @(posedge pclk);
    wr(`IDX_CONTROL_A, 32'h0);
    apb(1'b0, `IDX_INT_FLAGS, 32'h0, r2, er);
    chk({31'h0, r2[`BIT_WRAP]}, 32'h1, "underflow flag");
    wr(`IDX_INT_FLAGS, 32'h71);
    wr(`IDX_CONTROL_E, 32'h0);
    wr(`IDX_COUNT, 32'h3c);
    wr(`IDX_CONTROL_A, 32'h51);
    repeat (10) @(posedge pclk);
    wr(`IDX_CONTROL_A, 32'h0);
    apb(1'b0, `IDX_INT_FLAGS, 32'h0, r2, er);
    chk({31'h0, r2[`BIT_WRAP]}, 32'h1, "dual slope top flag");
    wr(`IDX_CONTROL_E, 32'h0);
    wr(`IDX_INT_FLAGS, 32'h71);
    $display("test irq done");
  endtask

  // ==========================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_bufvalid();
    t_events();
    t_updown();
    t_irq();
    results();
  end
endmodule
